//--- rtl/hls_pkg.sv
package hls_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned STAGES = 11;
  localparam int unsigned E2_IDX = 10;
  localparam int unsigned STACK_DEPTH = 6;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // unrolled loops shorter than this always run late-check
  localparam logic [31:0] SHORT_LOOP_LIMIT = 32'h0000000b;
  // only counter-expired termination is modelled
  localparam logic [1:0] TERM_LCE = 2'h1;

  // what the fetch side reports for the word at the first fetch stage
  typedef struct packed {
    logic is_setup;
    logic late_op;
    logic [ADDR_W-1:0] end_addr;
  } hls_instr_t;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    hls_instr_t ins;
  } hls_stage_t;

  typedef struct packed {
    logic [ADDR_W-1:0] end_addr;
    logic [1:0] term;
    logic [CNT_W-1:0] saved_cnt;
  } hls_loop_ent_t;

  typedef struct packed {
    logic [ADDR_W-1:0] top_addr;
    logic late;
  } hls_pc_ent_t;

endpackage

//--- rtl/hls_loop_seq.sv
// What this block does
// - early-check loops decrement and test count when loop end sits in first fetch.
// - setup pushes loop end address and termination condition onto loop stack.
// - setup pushes top-of-loop (setup address plus one) and loop type on PC stack.
// - early-check termination not met at check: next fetch is top of PC stack.
// - setup pushes happen at final execute stage, ten cycles after first fetch.
// - loop end in first fetch with no exit means top-of-loop appears there next cycle.
// - termination fetches end address plus one and pops both stacks.
// - early-check terminates only when count is one with valid end in first fetch.
// - early-check exit fetches end plus one next cycle, no lost cycles.
// - late-check loops decrement and test count when loop end is in final execute.
// - late-check loops still loop back at first fetch until terminated.
// - setup opcode selects early-check or late-check handling.
// - late-check termination flushes last memory stage back to first fetch.
// - force-late-check bit makes every counter loop late-check.
// - loops with fewer than eleven unrolled instructions run late-check.
`timescale 1ns/1ps
module hls_loop_seq #(
  parameter int unsigned DEPTH = hls_pkg::STACK_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire hls_pkg::hls_instr_t instr_i,
  input wire logic [hls_pkg::CNT_W-1:0] loop_count_init_i,
  input wire logic force_late_check_loops_i,
  output logic [hls_pkg::ADDR_W-1:0] fetch_addr_o,
  output logic loop_back_o,
  output logic loop_exit_o,
  output logic flush_o,
  output logic stack_full_o,
  output logic [hls_pkg::CNT_W-1:0] current_loop_count_o,
  output logic [$clog2(DEPTH+1)-1:0] loop_depth_o
);

  localparam int unsigned SP_W = $clog2(DEPTH+1);
  localparam int unsigned IX_W = $clog2(DEPTH);

  hls_pkg::hls_stage_t stg_q [1:hls_pkg::E2_IDX];
  hls_pkg::hls_stage_t f1_stg;
  hls_pkg::hls_loop_ent_t loop_stk_q [DEPTH];
  hls_pkg::hls_pc_ent_t pc_stk_q [DEPTH];
  hls_pkg::hls_loop_ent_t loop_top;
  hls_pkg::hls_pc_ent_t pc_top;
  logic [hls_pkg::ADDR_W-1:0] pc_q;
  logic [hls_pkg::ADDR_W-1:0] pc_d;
  logic [hls_pkg::CNT_W-1:0] cnt_q;
  logic [SP_W-1:0] sp_q;
  logic [IX_W-1:0] top_ix;
  logic [IX_W-1:0] push_ix;
  logic active;
  logic f1_hit;
  logic e2_hit;
  logic early_term;
  logic late_term;
  logic do_push;
  logic do_pop;
  logic push_ok;
  logic push_late;
  logic [31:0] unrolled;

  // loop end seen at a stage that belongs to the innermost loop
  function automatic logic end_hit(input hls_pkg::hls_stage_t s, input logic [hls_pkg::ADDR_W-1:0] end_a,
                                   input logic act);
    end_hit = act && s.valid && (s.addr == end_a);
  endfunction

  assign f1_stg = '{valid: 1'b1, addr: pc_q, ins: instr_i};
  assign active = (sp_q != '0);
  assign top_ix = active ? IX_W'(sp_q - SP_W'(1)) : '0;
  assign loop_top = loop_stk_q[top_ix];
  assign pc_top = pc_stk_q[top_ix];

  assign f1_hit = end_hit(f1_stg, loop_top.end_addr, active);
  assign e2_hit = end_hit(stg_q[hls_pkg::E2_IDX], loop_top.end_addr, active);
  assign early_term = f1_hit && !pc_top.late && (cnt_q == hls_pkg::CNT_ONE);
  assign late_term = e2_hit && pc_top.late && (cnt_q == hls_pkg::CNT_ONE);

  // late exit owns the cycle: the loop-back at first fetch is flushed with it
  assign loop_back_o = f1_hit && !early_term && !late_term;
  assign loop_exit_o = early_term || late_term;
  assign flush_o = late_term;
  assign do_pop = loop_exit_o;
  assign do_push = stg_q[hls_pkg::E2_IDX].valid && stg_q[hls_pkg::E2_IDX].ins.is_setup && !late_term;
  assign push_ok = do_push && (do_pop || !stack_full_o);
  assign push_ix = do_pop ? top_ix : IX_W'(sp_q);
  assign stack_full_o = (sp_q == SP_W'(DEPTH));

  // unrolled length = count times body length, body runs setup+1 .. end
  assign unrolled = 32'(loop_count_init_i) *
                    32'(stg_q[hls_pkg::E2_IDX].ins.end_addr - stg_q[hls_pkg::E2_IDX].addr);
  assign push_late = stg_q[hls_pkg::E2_IDX].ins.late_op
                     || force_late_check_loops_i
                     || (unrolled < hls_pkg::SHORT_LOOP_LIMIT);

  always_comb begin
    pc_d = pc_q + hls_pkg::ADDR_W'(1);
    if (late_term) begin
      pc_d = loop_top.end_addr + hls_pkg::ADDR_W'(1);
    end else if (loop_back_o) begin
      pc_d = pc_top.top_addr;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_q <= hls_pkg::RESET_ADDR;
    end else begin
      pc_q <= pc_d;
    end
  end

  // one instruction per cycle; a late exit kills everything behind execute
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 1; i <= hls_pkg::E2_IDX; i++) begin
        stg_q[i] <= '0;
      end
    end else begin
      stg_q[1] <= late_term ? '0 : f1_stg;
      for (int i = 2; i <= hls_pkg::E2_IDX; i++) begin
        stg_q[i] <= late_term ? '0 : stg_q[i-1];
      end
    end
  end

  // a push while full is dropped unless a loop exits in the same cycle; a nest that deep is a software error
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sp_q <= '0;
    end else if (do_push && do_pop) begin
      sp_q <= sp_q;
    end else if (do_push && !stack_full_o) begin
      sp_q <= sp_q + SP_W'(1);
    end else if (do_pop) begin
      sp_q <= sp_q - SP_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        loop_stk_q[i] <= '0;
        pc_stk_q[i] <= '0;
      end
    end else if (push_ok) begin
      loop_stk_q[push_ix] <= '{end_addr: stg_q[hls_pkg::E2_IDX].ins.end_addr,
                               term: hls_pkg::TERM_LCE,
                               saved_cnt: do_pop ? loop_top.saved_cnt : cnt_q};
      pc_stk_q[push_ix] <= '{top_addr: stg_q[hls_pkg::E2_IDX].addr + hls_pkg::ADDR_W'(1),
                             late: push_late};
    end
  end

  // outer loop count is kept on the loop stack and comes back on exit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= hls_pkg::CNT_RESET;
    end else if (push_ok) begin
      cnt_q <= loop_count_init_i;
    end else if (do_pop) begin
      cnt_q <= loop_top.saved_cnt;
    end else if (f1_hit && !pc_top.late) begin
      cnt_q <= cnt_q - hls_pkg::CNT_W'(1);
    end else if (e2_hit && pc_top.late) begin
      cnt_q <= cnt_q - hls_pkg::CNT_W'(1);
    end
  end

  assign fetch_addr_o = pc_q;
  assign current_loop_count_o = cnt_q;
  assign loop_depth_o = sp_q;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_PUSH_DEPTH: assert property (do_push && !do_pop && !stack_full_o |=> loop_depth_o == $past(loop_depth_o) + 1'b1)
    else $error("setup at execute did not push the stacks");
  AST_PUSH_TOP: assert property (do_push && !do_pop && !stack_full_o
                                 |=> pc_top.top_addr == $past(stg_q[hls_pkg::E2_IDX].addr) + 1'b1)
    else $error("top-of-loop address is not setup address plus one");
  AST_SETUP_AT_E2: assert property (stg_q[hls_pkg::E2_IDX].valid && stg_q[hls_pkg::E2_IDX].ins.is_setup
                                    |-> $past(instr_i.is_setup, 10))
    else $error("setup reached execute without entering fetch ten cycles earlier");
  AST_LOOPBACK: assert property (loop_back_o |=> fetch_addr_o == $past(pc_top.top_addr))
    else $error("loop-back did not fetch the top-of-loop address next cycle");
  AST_EARLY_EXIT: assert property (early_term |=> fetch_addr_o == $past(fetch_addr_o) + 1'b1 && !flush_o)
    else $error("early exit did not fetch end plus one next cycle");
  AST_TERM_ONE: assert property (loop_exit_o |-> current_loop_count_o == hls_pkg::CNT_ONE)
    else $error("loop ended with count not one");
  AST_POP: assert property (loop_exit_o && !do_push |=> loop_depth_o == $past(loop_depth_o) - 1'b1)
    else $error("loop exit did not pop the stacks");
  AST_LATE_FLUSH: assert property (late_term |=> !stg_q[hls_pkg::E2_IDX].valid && !stg_q[1].valid
                                   ##1 !stg_q[hls_pkg::E2_IDX].valid)
    else $error("late exit left work in the pipe");
  AST_EARLY_DECR: assert property (f1_hit && !pc_top.late && !early_term && !do_push
                                   |=> current_loop_count_o == $past(current_loop_count_o) - 1'b1)
    else $error("early-check loop count not decremented at first fetch");
  AST_LATE_DECR: assert property (e2_hit && pc_top.late && !late_term && !do_push
                                  |=> current_loop_count_o == $past(current_loop_count_o) - 1'b1)
    else $error("late-check loop count not decremented at execute");
  AST_FORCE_LATE: assert property (do_push && !do_pop && !stack_full_o && force_late_check_loops_i
                                   |=> pc_top.late)
    else $error("forced late-check loop pushed as early-check");
  AST_LATE_NO_F1_EXIT: assert property (f1_hit && pc_top.late |-> !early_term)
    else $error("late-check loop ended at first fetch");

  // pushed loop end and condition land on top
  AST_PUSH_END: assert property (push_ok && !do_pop
    |=> loop_top.end_addr == $past(stg_q[hls_pkg::E2_IDX].ins.end_addr) && loop_top.term == hls_pkg::TERM_LCE)
    else $error("loop stack top does not hold the pushed loop end");

  // count taken from the init input at setup execute
  AST_PUSH_LOAD: assert property (push_ok
    |=> current_loop_count_o == $past(loop_count_init_i))
    else $error("loop count not loaded at setup execute");

  // outer count comes back when the inner loop ends
  AST_POP_RESTORE: assert property (do_pop && !do_push
    |=> current_loop_count_o == $past(loop_top.saved_cnt))
    else $error("outer loop count not restored on exit");

  // late exit resumes right after the loop end
  AST_LATE_EXIT_FETCH: assert property (late_term
    |=> fetch_addr_o == $past(loop_top.end_addr) + 1'b1)
    else $error("late exit did not fetch end plus one");

  // early exit resumes right after the loop end
  AST_EARLY_EXIT_FETCH: assert property (early_term
    |=> fetch_addr_o == $past(loop_top.end_addr) + 1'b1)
    else $error("early exit did not fetch end plus one");

  // without loop events fetch just steps by one
  AST_SEQ_FETCH: assert property (!loop_back_o && !loop_exit_o
    |=> fetch_addr_o == $past(fetch_addr_o) + 1'b1)
    else $error("fetch address did not step by one");

  // stage 2 takes stage 1's word on every cycle without a late exit
  AST_PIPE_SHIFT: assert property (!late_term
    |=> stg_q[2] == $past(stg_q[1]))
    else $error("pipeline did not advance one stage");

  // the fetched word enters the pipe behind first fetch
  AST_PIPE_ENTER: assert property (!late_term
    |=> stg_q[1] == $past(f1_stg))
    else $error("fetched word did not enter the pipe");

  // late loops still turn back at first fetch
  AST_LATE_BACK: assert property (f1_hit && pc_top.late && !late_term
    |-> loop_back_o)
    else $error("late-check loop did not loop back at first fetch");

  // late loops leave the count alone at first fetch
  AST_LATE_NO_F1_DECR: assert property (f1_hit && pc_top.late && !e2_hit && !do_push && !do_pop
    |=> $stable(current_loop_count_o))
    else $error("late-check loop count changed at first fetch");

  // early loops leave the count alone at execute
  AST_EARLY_NO_E2_DECR: assert property (e2_hit && !pc_top.late && !f1_hit && !do_push && !do_pop
    |=> $stable(current_loop_count_o))
    else $error("early-check loop count changed at execute");

  // late opcode always gives a late loop
  AST_OPCODE_LATE: assert property (push_ok && !do_pop && stg_q[hls_pkg::E2_IDX].ins.late_op
    |=> pc_top.late)
    else $error("late opcode pushed as early-check");

  // early opcode stays early when nothing overrides it
  AST_OPCODE_EARLY: assert property (push_ok && !do_pop && !stg_q[hls_pkg::E2_IDX].ins.late_op
    && !force_late_check_loops_i && unrolled >= hls_pkg::SHORT_LOOP_LIMIT |=> !pc_top.late)
    else $error("early opcode pushed as late-check");

  // short unrolled loops are forced late
  AST_SHORT_LATE: assert property (push_ok && !do_pop && unrolled < hls_pkg::SHORT_LOOP_LIMIT
    |=> pc_top.late)
    else $error("short loop pushed as early-check");

  // nothing loops back or exits with no loop active
  AST_IDLE_QUIET: assert property (loop_depth_o == '0
    |-> !loop_back_o && !loop_exit_o)
    else $error("loop event with empty loop stack");

  // a push into a full stack is dropped
  AST_FULL_HOLD: assert property (do_push && !do_pop && stack_full_o
    |=> $stable(loop_depth_o))
    else $error("push into full loop stack changed depth");

  // flush only comes with a late exit
  AST_LATE_ONLY_FLUSH: assert property (flush_o
    |-> loop_exit_o && !loop_back_o)
    else $error("flush without a late exit");

  // early exit only with the loop end in first fetch
  AST_EXIT_AT_END: assert property (early_term
    |-> fetch_addr_o == loop_top.end_addr && loop_depth_o != '0)
    else $error("early exit away from the loop end");

  COV_LOOPBACK: cover property (loop_back_o ##1 !loop_back_o);
  COV_EARLY_EXIT: cover property (early_term);
  COV_LATE_EXIT: cover property (late_term);
  COV_NESTED: cover property (loop_depth_o == SP_W'(2));
  COV_FORCED: cover property (push_ok && force_late_check_loops_i);

endmodule

//--- dv/hls_fetch_model.sv
`timescale 1ns/1ps
module hls_fetch_model (
  input wire logic [hls_pkg::ADDR_W-1:0] fetch_addr_i,
  input wire logic [hls_pkg::ADDR_W-1:0] setup_addr_i,
  input wire logic [hls_pkg::ADDR_W-1:0] end_addr_i,
  input wire logic late_op_i,
  output hls_pkg::hls_instr_t instr_o
);
  // plain words carry junk end fields so a design that ignores is_setup misbehaves
  always_comb begin
    instr_o.is_setup = 1'b0;
    instr_o.late_op = ~late_op_i;
    instr_o.end_addr = ~end_addr_i;
    if (fetch_addr_i == setup_addr_i) begin
      instr_o.is_setup = 1'b1;
      instr_o.late_op = late_op_i;
      instr_o.end_addr = end_addr_i;
    end
  end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic late_op = 1'b0;
  logic force_late = 1'b0;
  logic [15:0] cnt_init = 16'h0000;
  hls_pkg::hls_instr_t instr;
  logic [15:0] fetch_addr_o;
  logic loop_back_o;
  logic loop_exit_o;
  logic flush_o;
  logic stack_full_o;
  logic [15:0] current_loop_count_o;
  logic [2:0] loop_depth_o;
  int n_fail = 0;
  int total_checks = 0;

  always #20 clk_i = ~clk_i;

  hls_fetch_model fm (.fetch_addr_i(fetch_addr_o), .setup_addr_i(16'h0004), .end_addr_i(16'h001e),
    .late_op_i(late_op), .instr_o(instr));

  hls_loop_seq dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr), .loop_count_init_i(cnt_init),
    .force_late_check_loops_i(force_late), .fetch_addr_o(fetch_addr_o), .loop_back_o(loop_back_o),
    .loop_exit_o(loop_exit_o), .flush_o(flush_o), .stack_full_o(stack_full_o),
    .current_loop_count_o(current_loop_count_o), .loop_depth_o(loop_depth_o));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (exp !== seen) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (8) @(negedge clk_i);
    check("fetch_addr_o", 16'h0000, fetch_addr_o);
    check("loop_depth_o", 16'h0000, {13'h0000, loop_depth_o});
    rst_n_i = 1'b1;
  endtask

  // setup at 4, loop end at 30; body long enough that no short-loop override applies
  task automatic run_loop(input logic late, input logic frc, input logic [15:0] cnt,
                          input logic [15:0] exp_backs, input logic exp_flush);
    int cyc;
    int t0;
    logic [15:0] backs;
    logic [15:0] nxt;
    logic ended;
    logic done;
    t0 = -1;
    backs = 16'h0000;
    nxt = 16'h0000;
    ended = 1'b0;
    done = 1'b0;
    late_op = late;
    force_late = frc;
    cnt_init = cnt;
    do_reset();
    for (cyc = 0; cyc < 400 && !done; cyc++) begin
      @(negedge clk_i);
      if (cyc > 0) check("fetch_addr_o", nxt, fetch_addr_o);
      if (ended) begin
        check("loop_depth_o", 16'h0000, {13'h0000, loop_depth_o});
        done = 1'b1;
      end
      if (fetch_addr_o === 16'h0004 && t0 < 0) t0 = cyc;
      if (t0 >= 0 && cyc == t0 + 10) check("loop_depth_o", 16'h0000, {13'h0000, loop_depth_o});
      if (t0 >= 0 && cyc == t0 + 11) begin
        check("loop_depth_o", 16'h0001, {13'h0000, loop_depth_o});
        check("current_loop_count_o", cnt, current_loop_count_o);
        check("stack_full_o", 16'h0000, {15'h0000, stack_full_o});
      end
      nxt = fetch_addr_o + 16'h0001;
      if (loop_back_o === 1'b1) begin
        backs = backs + 16'h0001;
        nxt = 16'h0005;
      end
      if (loop_exit_o === 1'b1 && !ended) begin
        check("current_loop_count_o", 16'h0001, current_loop_count_o);
        check("flush_o", {15'h0000, exp_flush}, {15'h0000, flush_o});
        nxt = 16'h001f;
        ended = 1'b1;
      end
    end
    if (!done) begin
      n_fail++;
      $display("unexpected loop_exit_o expected 1 seen 0");
      finish_test();
    end
    check("loop_back count", exp_backs, backs);
  endtask

  task automatic t_early();
    run_loop(1'b0, 1'b0, 16'h0006, 16'h0005, 1'b0);
  endtask

  task automatic t_late();
    run_loop(1'b1, 1'b0, 16'h0003, 16'h0003, 1'b1);
  endtask

  task automatic t_force();
    run_loop(1'b0, 1'b1, 16'h0003, 16'h0003, 1'b1);
  endtask

  initial begin
    t_early();
    t_late();
    t_force();
    finish_test();
  end
endmodule
